// >>> design/standby_pin_consts.svh
`ifndef STANDBY_PIN_CONSTS_SVH
`define STANDBY_PIN_CONSTS_SVH
// Pin count and register port widths.
`define PIN_COUNT 8
`define ADDR_W 4
`define DATA_W 8
// Register offsets on the plain register port.
`define OFS_CTRL 4'h0
`define OFS_FUNC 4'h1
`define OFS_EXTEN 4'h2
`define OFS_OSCSEL 4'h3
`define OFS_TOUCHSEL 4'h4
`define OFS_RSTSEL 4'h5
`define OFS_STATUS 4'h6
`define OFS_MASK 4'h7
`define OFS_PINS 4'h8
// Control register fields and reset value.
`define CTRL_MODE_LSB 0
`define CTRL_HOLD_BIT 2
`define CTRL_RESET 8'h00
// Function enable bits.
`define FN_TDOUT 0
`define FN_CMPOUT 1
`define FN_TONE 2
`define FN_TRUN 3
`define FN_I2CW 4
`define FN_CMPIRQ 5
`define FN_TIRQ 6
// Status and mask bit positions.
`define ST_EXTI 0
`define ST_CMP 1
`define ST_TOUCH 2
`define ST_I2C 3
`define ST_W 4
// Per-pin capability masks, one bit per pin.
`define CAP_OSC 8'h03
`define CAP_RST 8'h04
`define CAP_TDOUT 8'h08
`define CAP_TONE 8'h08
`define CAP_CMPOUT 8'h10
`define CAP_CMPIN 8'h20
`define CAP_EXTI 8'h30
`define CAP_TOUCH 8'hc0
`define CAP_I2C 8'h30
`endif

// >>> design/standby_pin_pkg.sv
package standby_pin_pkg;
    // Power modes of the device as seen by the pins.
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_SLEEP,
        MODE_STOP,
        MODE_WATCH
    } power_mode_e;
endpackage : standby_pin_pkg

// >>> design/sticky_irq.sv
`timescale 1ns/1ps
`default_nettype none
`include "standby_pin_consts.svh"
module sticky_irq (
    input wire logic clock_i, // Machine clock.
    input wire logic resetn_i, // Synchronous reset, active low.
    input wire logic [`ST_W-1:0] set_i, // Event pulses.
    input wire logic clr_i, // Status read pulse.
    input wire logic [`ST_W-1:0] mask_i, // Interrupt enables.
    output logic [`ST_W-1:0] status_o, // Sticky status.
    output logic irq_o // Level interrupt.
);
    logic [`ST_W-1:0] status_reg;

    // A read clears the bits, but an event in the same cycle survives.
    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
            status_reg <= '0;
        else if (clr_i)
            status_reg <= set_i;
        else
            status_reg <= status_reg | set_i;
    end

    assign status_o = status_reg;
    assign irq_o = |(status_reg & mask_i);

    property p_set_wins;
        @(posedge clock_i) disable iff (!resetn_i)
        (set_i != '0) |=> ((status_reg & $past(set_i)) == $past(set_i));
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("Event lost against status clear.");
endmodule : sticky_irq
`default_nettype wire

// >>> design/pin_state_cell.sv
`timescale 1ns/1ps
`default_nettype none
`include "standby_pin_consts.svh"
module pin_state_cell #(
    parameter bit CAP_OSC = 1'b0,
    parameter bit CAP_RST = 1'b0,
    parameter bit CAP_TOUCH = 1'b0,
    parameter bit CAP_TDOUT = 1'b0,
    parameter bit CAP_CMPOUT = 1'b0,
    parameter bit CAP_TONE = 1'b0
) (
    input wire logic clock_i, // Machine clock.
    input wire logic resetn_i, // Synchronous reset, active low.
    input wire standby_pin_pkg::power_mode_e mode_i, // Power mode.
    input wire logic hold_sel_i, // Pin hold select.
    input wire logic osc_sel_i, // Pin in oscillation use.
    input wire logic rst_sel_i, // Pin in reset use.
    input wire logic touch_sel_i, // Pin as touch input.
    input wire logic [7:0] func_i, // Function enables.
    input wire logic core_out_i, // Port or peripheral output.
    input wire logic core_oe_i, // Port or peripheral enable.
    input wire logic touch_dout_i, // Touch direct output.
    input wire logic cmp_out_i, // Comparator output.
    input wire logic tone_i, // Tone output.
    input wire logic sense_clk_i, // Touch sense clock.
    output logic pad_out_o, // Pad output level.
    output logic pad_oe_o, // Pad output enable.
    output logic in_en_o // Input gate enable.
);
    logic standby;
    logic out_next;
    logic oe_next;
    logic ien_next;
    logic held_out_reg;
    logic held_oe_reg;

    assign standby = (mode_i == standby_pin_pkg::MODE_STOP)
        || (mode_i == standby_pin_pkg::MODE_WATCH);

    // Pin drive and input gate for the present mode.
    always_comb
    begin
        out_next = core_out_i; // R16
        oe_next = core_oe_i;
        ien_next = 1'b1;
        if (standby)
        begin
            ien_next = 1'b0; // R2
            out_next = held_out_reg; // R1
            oe_next = held_oe_reg && !hold_sel_i; // R1
            if (!hold_sel_i && CAP_TDOUT && func_i[`FN_TDOUT])
            begin
                out_next = touch_dout_i; // R6
                oe_next = 1'b1;
            end
            else if (!hold_sel_i && CAP_CMPOUT && func_i[`FN_CMPOUT])
            begin
                out_next = cmp_out_i; // R10
                oe_next = 1'b1;
            end
            else if (!hold_sel_i && CAP_TONE && func_i[`FN_TONE])
            begin
                out_next = tone_i; // R11
                oe_next = 1'b1;
            end
            if (CAP_TOUCH && touch_sel_i && func_i[`FN_TRUN])
            begin
                out_next = sense_clk_i; // R13
                oe_next = 1'b1;
            end
        end
        if (CAP_OSC && osc_sel_i)
        begin
            oe_next = 1'b0; // R5
            ien_next = 1'b0;
        end
        if (CAP_RST && rst_sel_i)
        begin
            oe_next = 1'b0; // R15
            ien_next = 1'b1;
        end
    end

    // Pad registers; reset floats every pin, output ports included.
    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            pad_out_o <= 1'b0;
            pad_oe_o <= 1'b0; // R3 R4
            in_en_o <= !CAP_TOUCH; // R3
        end
        else
        begin
            pad_out_o <= out_next;
            pad_oe_o <= oe_next;
            in_en_o <= ien_next;
        end
    end

    // The state shown before standby is what a held pin keeps.
    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            held_out_reg <= 1'b0;
            held_oe_reg <= 1'b0;
        end
        else if (!standby)
        begin
            held_out_reg <= pad_out_o;
            held_oe_reg <= pad_oe_o;
        end
    end

    property p_hold_hiz;
        @(posedge clock_i) disable iff (!resetn_i)
        (standby && hold_sel_i && !(CAP_TOUCH && touch_sel_i)) |=> !pad_oe_o;
    endproperty
    a_hold_hiz: assert property (p_hold_hiz) // R1
        else $error("Held pin not floating with hold select set.");

    property p_in_block;
        @(posedge clock_i) disable iff (!resetn_i)
        (standby && !(CAP_RST && rst_sel_i)) |=> !in_en_o;
    endproperty
    a_in_block: assert property (p_in_block) // R2
        else $error("Input gate open in standby.");

    property p_sleep_follow;
        @(posedge clock_i) disable iff (!resetn_i)
        (mode_i == standby_pin_pkg::MODE_SLEEP && !osc_sel_i && !rst_sel_i)
        |=> (pad_oe_o == $past(core_oe_i)) && (pad_out_o == $past(core_out_i));
    endproperty
    a_sleep_follow: assert property (p_sleep_follow) // R16
        else $error("Sleep mode pin differs from normal drive.");
endmodule : pin_state_cell
`default_nettype wire

// >>> design/standby_pin_state_control.sv
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "standby_pin_consts.svh"
// Summary of operation
// R1 - In stop and watch mode a pin keeps its last output when hold select is 0 and floats when 1.
// R2 - A blocked pin has its direct input gate into the core switched off.
// R3 - In reset ordinary pins float with input enabled but unused, and touch pins float blocked.
// R4 - A pin used as an output port floats in reset like every other port.
// R5 - An oscillator-capable pin in oscillation use floats and never drives.
// R6 - In standby a pin gives the touch direct output only with hold select 0 and that output on.
// R7 - The pull-up control setting stays in force on floating pins.
// R8 - A blocked pin still feeds the external interrupt logic while that request is enabled.
// R9 - A blocked pin still feeds the comparator while the comparator interrupt is enabled.
// R10 - In standby a pin gives the comparator output only with hold select 0 and that output on.
// R11 - In standby a pin gives the tone output only with hold select 0 and that output on.
// R12 - The I2C unit can wake the device from standby when its wakeup is enabled.
// R13 - In standby a touch pin drives the sense clock only as touch input with the unit running.
// R14 - A blocked touch pin still passes touch signals to raise the touch interrupt if enabled.
// R15 - The shared reset pin takes its reset-input states only when set for reset use.
// R16 - In sleep mode each pin behaves as in normal operation with no hold or blocking.
module standby_pin_state_control (
    input wire logic clock_i, // Machine clock, 40 MHz.
    input wire logic resetn_i, // Synchronous reset, active low.
    input wire logic [`ADDR_W-1:0] addr_i, // Register address.
    input wire logic [`DATA_W-1:0] wdata_i, // Register write data.
    input wire logic wr_i, // Write strobe.
    input wire logic rd_i, // Read strobe.
    output logic [`DATA_W-1:0] rdata_o, // Read data, next cycle.
    input wire logic [`PIN_COUNT-1:0] core_out_i, // Port outputs.
    input wire logic [`PIN_COUNT-1:0] core_oe_i, // Port output enables.
    input wire logic [`PIN_COUNT-1:0] pullup_i, // Pull-up settings.
    input wire logic [`PIN_COUNT-1:0] pad_in_i, // Pad input levels.
    input wire logic touch_dout_i, // Touch direct output.
    input wire logic comparator_out_i, // Comparator output.
    input wire logic tone_i, // Tone output.
    input wire logic touch_sense_clock_i, // Touch sense clock.
    input wire logic cmp_event_i, // Comparator event pulse.
    input wire logic touch_interrupt_i, // Touch event pulse.
    input wire logic i2c_wake_req_i, // I2C address match pulse.
    output logic [`PIN_COUNT-1:0] pad_out_o, // Pad output levels.
    output logic [`PIN_COUNT-1:0] pad_oe_o, // Pad output enables.
    output logic [`PIN_COUNT-1:0] pad_pull_o, // Pad pull-up enables.
    output logic [`PIN_COUNT-1:0] pad_in_en_o, // Pad input gates.
    output logic [`PIN_COUNT-1:0] core_in_o, // Gated pin inputs.
    output logic [`PIN_COUNT-1:0] ext_irq_in_o, // To external interrupts.
    output logic [`PIN_COUNT-1:0] cmp_analog_en_o, // Analog path enables.
    output logic [`PIN_COUNT-1:0] touch_in_o, // To touch sensor unit.
    output logic [`PIN_COUNT-1:0] i2c_pin_in_o, // To I2C wake logic.
    output logic standby_o, // Stop or watch mode.
    output logic wake_o, // Standby wakeup pulse.
    output logic irq_o // Interrupt, level.
);
    localparam logic [`PIN_COUNT-1:0] CAP_OSC_V = `CAP_OSC;
    localparam logic [`PIN_COUNT-1:0] CAP_RST_V = `CAP_RST;
    localparam logic [`PIN_COUNT-1:0] CAP_TOUCH_V = `CAP_TOUCH;
    localparam logic [`PIN_COUNT-1:0] CAP_TDOUT_V = `CAP_TDOUT;
    localparam logic [`PIN_COUNT-1:0] CAP_CMPOUT_V = `CAP_CMPOUT;
    localparam logic [`PIN_COUNT-1:0] CAP_TONE_V = `CAP_TONE;
    localparam logic [`PIN_COUNT-1:0] CAP_CMPIN_V = `CAP_CMPIN;
    localparam logic [`PIN_COUNT-1:0] CAP_EXTI_V = `CAP_EXTI;
    localparam logic [`PIN_COUNT-1:0] CAP_I2C_V = `CAP_I2C;
    localparam logic [`DATA_W-1:0] CTRL_RESET_V = `CTRL_RESET;

    standby_pin_pkg::power_mode_e mode_reg;
    logic hold_sel_reg;
    logic [`DATA_W-1:0] func_reg;
    logic [`PIN_COUNT-1:0] ext_en_reg;
    logic [`PIN_COUNT-1:0] osc_sel_reg;
    logic [`PIN_COUNT-1:0] touch_sel_reg;
    logic [`PIN_COUNT-1:0] rst_sel_reg;
    logic [`ST_W-1:0] mask_reg;
    logic [`ST_W-1:0] status;
    logic [`ST_W-1:0] events;
    logic [`PIN_COUNT-1:0] exti_prev_reg;
    logic run_reg;
    logic standby;
    logic status_rd;
    logic [`DATA_W-1:0] rdata_next;

    assign standby = (mode_reg == standby_pin_pkg::MODE_STOP)
        || (mode_reg == standby_pin_pkg::MODE_WATCH);
    assign standby_o = standby;
    assign status_rd = rd_i && (addr_i == `OFS_STATUS);

    // Control register: power mode and pin hold select.
    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            mode_reg <= standby_pin_pkg::MODE_RUN;
            hold_sel_reg <= CTRL_RESET_V[`CTRL_HOLD_BIT];
        end
        else if (wr_i && (addr_i == `OFS_CTRL))
        begin
            mode_reg <= standby_pin_pkg::power_mode_e'(wdata_i[`CTRL_MODE_LSB +: 2]);
            hold_sel_reg <= wdata_i[`CTRL_HOLD_BIT];
        end
        else if (standby && wake_o)
        begin
            mode_reg <= standby_pin_pkg::MODE_RUN;
        end
    end

    // Function enables and per-pin configuration registers.
    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            func_reg <= '0;
            ext_en_reg <= '0;
            osc_sel_reg <= '0;
            touch_sel_reg <= '0;
            rst_sel_reg <= CAP_RST_V;
            mask_reg <= '0;
        end
        else if (wr_i)
        begin
            if (addr_i == `OFS_FUNC)
                func_reg <= wdata_i;
            else if (addr_i == `OFS_EXTEN)
                ext_en_reg <= wdata_i & CAP_EXTI_V;
            else if (addr_i == `OFS_OSCSEL)
                osc_sel_reg <= wdata_i & CAP_OSC_V;
            else if (addr_i == `OFS_TOUCHSEL)
                touch_sel_reg <= wdata_i & CAP_TOUCH_V;
            else if (addr_i == `OFS_RSTSEL)
                rst_sel_reg <= wdata_i & CAP_RST_V;
            else if (addr_i == `OFS_MASK)
                mask_reg <= wdata_i[`ST_W-1:0];
        end
    end

    // Read data for the addressed register; unmapped reads return zero.
    always_comb
    begin
        rdata_next = '0;
        if (addr_i == `OFS_CTRL)
        begin
            rdata_next[`CTRL_MODE_LSB +: 2] = mode_reg;
            rdata_next[`CTRL_HOLD_BIT] = hold_sel_reg;
        end
        else if (addr_i == `OFS_FUNC)
            rdata_next = func_reg;
        else if (addr_i == `OFS_EXTEN)
            rdata_next = ext_en_reg;
        else if (addr_i == `OFS_OSCSEL)
            rdata_next = osc_sel_reg;
        else if (addr_i == `OFS_TOUCHSEL)
            rdata_next = touch_sel_reg;
        else if (addr_i == `OFS_RSTSEL)
            rdata_next = rst_sel_reg;
        else if (addr_i == `OFS_STATUS)
            rdata_next[`ST_W-1:0] = status;
        else if (addr_i == `OFS_MASK)
            rdata_next[`ST_W-1:0] = mask_reg;
        else if (addr_i == `OFS_PINS)
            rdata_next = pad_in_i;
    end

    // Read data register, valid only in the cycle after the strobe.
    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
            rdata_o <= '0;
        else if (rd_i)
            rdata_o <= rdata_next;
        else
            rdata_o <= '0;
    end

    // Inputs reach the core only once reset is over.
    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
            run_reg <= 1'b0;
        else
            run_reg <= 1'b1;
    end

    // One cell per pin sets drive and input gate.
    for (genvar i = 0; i < `PIN_COUNT; i++)
    begin : g_pin
        pin_state_cell #(
            .CAP_OSC(CAP_OSC_V[i]),
            .CAP_RST(CAP_RST_V[i]),
            .CAP_TOUCH(CAP_TOUCH_V[i]),
            .CAP_TDOUT(CAP_TDOUT_V[i]),
            .CAP_CMPOUT(CAP_CMPOUT_V[i]),
            .CAP_TONE(CAP_TONE_V[i])
        ) u_cell (
            .clock_i(clock_i),
            .resetn_i(resetn_i),
            .mode_i(mode_reg),
            .hold_sel_i(hold_sel_reg),
            .osc_sel_i(osc_sel_reg[i]),
            .rst_sel_i(rst_sel_reg[i]),
            .touch_sel_i(touch_sel_reg[i]),
            .func_i(func_reg),
            .core_out_i(core_out_i[i]),
            .core_oe_i(core_oe_i[i]),
            .touch_dout_i(touch_dout_i),
            .cmp_out_i(comparator_out_i),
            .tone_i(tone_i),
            .sense_clk_i(touch_sense_clock_i),
            .pad_out_o(pad_out_o[i]),
            .pad_oe_o(pad_oe_o[i]),
            .in_en_o(pad_in_en_o[i])
        );
    end

    // Core input gate, and the paths that survive input blocking.
    always_comb
    begin
        pad_pull_o = pullup_i; // R7
        core_in_o = pad_in_i & pad_in_en_o & {`PIN_COUNT{run_reg}}; // R3
        ext_irq_in_o = pad_in_i & ext_en_reg; // R8
        cmp_analog_en_o = CAP_CMPIN_V & {`PIN_COUNT{func_reg[`FN_CMPIRQ]}}; // R9
        touch_in_o = pad_in_i & touch_sel_reg
            & {`PIN_COUNT{!standby || func_reg[`FN_TIRQ]}}; // R14
        i2c_pin_in_o = pad_in_i & CAP_I2C_V
            & {`PIN_COUNT{!standby || func_reg[`FN_I2CW]}}; // R12
    end

    // Rising edges on the external interrupt paths.
    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
            exti_prev_reg <= '0;
        else
            exti_prev_reg <= ext_irq_in_o;
    end

    // Events that set sticky status bits.
    always_comb
    begin
        events = '0;
        events[`ST_EXTI] = |(ext_irq_in_o & ~exti_prev_reg); // R8
        events[`ST_CMP] = cmp_event_i && func_reg[`FN_CMPIRQ]; // R9
        events[`ST_TOUCH] = touch_interrupt_i && func_reg[`FN_TIRQ]; // R14
        events[`ST_I2C] = i2c_wake_req_i && func_reg[`FN_I2CW]; // R12
    end

    sticky_irq u_irq (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .set_i(events),
        .clr_i(status_rd),
        .mask_i(mask_reg),
        .status_o(status),
        .irq_o(irq_o)
    );

    // Wakeup from standby on any enabled event; I2C wakes regardless of mask.
    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
            wake_o <= 1'b0;
        else
            wake_o <= standby && (|(events & mask_reg) || events[`ST_I2C]); // R12
    end

    property p_reset_float;
        @(posedge clock_i)
        !resetn_i |=> (pad_oe_o == '0) && (pad_in_en_o == ~CAP_TOUCH_V);
    endproperty
    a_reset_float: assert property (p_reset_float) // R3
        else $error("Pins not in reset state after reset.");

    property p_reset_ports;
        @(posedge clock_i)
        (!resetn_i && core_oe_i != '0) |=> (pad_oe_o == '0);
    endproperty
    a_reset_ports: assert property (p_reset_ports) // R4
        else $error("Output port drives during reset.");

    property p_osc_float;
        @(posedge clock_i) disable iff (!resetn_i)
        (osc_sel_reg != '0) |=> ((pad_oe_o & $past(osc_sel_reg)) == '0);
    endproperty
    a_osc_float: assert property (p_osc_float) // R5
        else $error("Oscillation pin drives.");

    property p_pull_kept;
        @(posedge clock_i) disable iff (!resetn_i)
        standby |-> (pad_pull_o == pullup_i);
    endproperty
    a_pull_kept: assert property (p_pull_kept) // R7
        else $error("Pull-up setting lost in standby.");

    sequence s_exti_edge;
        (standby && ext_en_reg != '0 && (ext_irq_in_o & ~exti_prev_reg) != '0);
    endsequence

    property p_exti_pass;
        @(posedge clock_i) disable iff (!resetn_i)
        s_exti_edge |=> status[`ST_EXTI];
    endproperty
    a_exti_pass: assert property (p_exti_pass) // R8
        else $error("External interrupt lost while input blocked.");

    sequence s_i2c_req;
        (standby && i2c_wake_req_i && func_reg[`FN_I2CW]);
    endsequence

    property p_i2c_wake;
        @(posedge clock_i) disable iff (!resetn_i)
        s_i2c_req |=> wake_o ##1 (mode_reg == standby_pin_pkg::MODE_RUN);
    endproperty
    a_i2c_wake: assert property (p_i2c_wake) // R12
        else $error("I2C request did not wake the device.");

    property p_tdout;
        @(posedge clock_i) disable iff (!resetn_i)
        (standby && !hold_sel_reg && func_reg[`FN_TDOUT]
            && rst_sel_reg == '0 && osc_sel_reg == '0)
        |=> ((pad_oe_o & CAP_TDOUT_V) == CAP_TDOUT_V);
    endproperty
    a_tdout: assert property (p_tdout) // R6
        else $error("Touch direct output pin not driving.");

    property p_sense_clk;
        @(posedge clock_i) disable iff (!resetn_i)
        (standby && func_reg[`FN_TRUN] && touch_sel_reg != '0)
        |=> ((pad_oe_o & $past(touch_sel_reg)) == $past(touch_sel_reg));
    endproperty
    a_sense_clk: assert property (p_sense_clk) // R13
        else $error("Touch pin not driving sense clock.");

    property p_touch_irq;
        @(posedge clock_i) disable iff (!resetn_i)
        (touch_interrupt_i && func_reg[`FN_TIRQ] && mask_reg[`ST_TOUCH]) |=> irq_o;
    endproperty
    a_touch_irq: assert property (p_touch_irq) // R14
        else $error("Touch event raised no interrupt.");

    property p_rst_pin;
        @(posedge clock_i) disable iff (!resetn_i)
        (rst_sel_reg != '0) |=> ((pad_in_en_o & $past(rst_sel_reg)) == $past(rst_sel_reg));
    endproperty
    a_rst_pin: assert property (p_rst_pin) // R15
        else $error("Reset pin input gate closed in reset use.");
endmodule : standby_pin_state_control
`default_nettype wire

// >>> test/board_model.sv
`timescale 1ns/1ps
`default_nettype none
module board_model (
    input wire logic clock_i, // Machine clock.
    input wire logic [7:0] pad_out_i, // Device drive level.
    input wire logic [7:0] pad_oe_i, // Device drive enable.
    input wire logic [7:0] pull_i, // Device pull-up enable.
    input wire logic [7:0] ext_i, // Board source level.
    output logic [7:0] pad_o // Resolved pad level.
);
    logic [7:0] flip_reg = 8'h00;
    // An undriven pad with no pull-up toggles every cycle, so no stale level survives.
    always @(posedge clock_i)
        flip_reg <= ~flip_reg;
    // A driven pad shows the device level, a pulled one reads high.
    assign pad_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & (pull_i | (ext_i ^ flip_reg)));
endmodule : board_model
`default_nettype wire

// >>> test/standby_pin_state_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "standby_pin_consts.svh"
module standby_pin_state_control_test;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] cout = 8'h00;
    logic [7:0] coe = 8'hff;
    logic [7:0] pull = 8'h00;
    logic [7:0] ext = 8'h00;
    logic [3:0] src = 4'h0;
    logic [2:0] evs = 3'h0;
    logic [7:0] rdata, pout, poe, ppull, pen, cin, eirq, cmpen, tin, pad, d, oe0, out0, e, i2c;
    logic stby, wake, irq;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    int wakes = 0;
    int w0;
    logic [31:0] rng = 32'd94244;
    logic [7:0] pinm [4] = '{8'h08, 8'h10, 8'h08, 8'hc0};
    standby_pin_state_control DUT (.clock_i(clk), .resetn_i(resetn), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .core_out_i(cout),
        .core_oe_i(coe), .pullup_i(pull), .pad_in_i(pad), .touch_dout_i(src[0]),
        .comparator_out_i(src[1]), .tone_i(src[2]), .touch_sense_clock_i(src[3]),
        .cmp_event_i(evs[0]), .touch_interrupt_i(evs[1]), .i2c_wake_req_i(evs[2]),
        .pad_out_o(pout), .pad_oe_o(poe), .pad_pull_o(ppull), .pad_in_en_o(pen),
        .core_in_o(cin), .ext_irq_in_o(eirq), .cmp_analog_en_o(cmpen), .touch_in_o(tin),
        .i2c_pin_in_o(i2c), .standby_o(stby), .wake_o(wake), .irq_o(irq));
    board_model board (.clock_i(clk), .pad_out_i(pout), .pad_oe_i(poe), .pull_i(ppull),
        .ext_i(ext), .pad_o(pad));
    // Machine clock, 25 ns period.
    always #12.5 clk = ~clk;
    // Watchdog and wake pulse counter.
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (wake === 1'b1)
            wakes <= wakes + 1;
        if (cycles == 5000)
        begin
            num_errors = num_errors + 1;
            final_report();
        end
    end
    // Xorshift source with a fixed start.
    function automatic logic [7:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng[7:0];
    endfunction : rnd
    // Standby with hold select 1 floats, with 0 keeps the old value, else it follows.
    function automatic logic [7:0] exp_pin(input logic [1:0] m, input logic h,
        input logic [7:0] old, input logic [7:0] now);
        if (m[1])
            return h ? 8'h00 : old;
        return now;
    endfunction : exp_pin
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wreg(input logic [3:0] a, input logic [7:0] v);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wreg
    task automatic rreg(input logic [3:0] a, output logic [7:0] v);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
        @(posedge clk);
    endtask : rreg
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    // Reset, then modes, special outputs and blocked paths.
    initial
    begin
        repeat (3) @(posedge clk);
        #1;
        chk("reset oe", poe, 8'h00);
        chk("reset gate", pen, 8'h3f);
        chk("reset core in", cin, 8'h00);
        @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rreg(`OFS_RSTSEL, d);
        chk("rstsel", d, 8'h04);
        rreg(4'hf, d);
        chk("unmapped", d, 8'h00);
        rreg(`OFS_PINS, d);
        chk("pins", d & 8'hfb, 8'h00);
        wreg(`OFS_RSTSEL, 8'h00);
        $display("Reset test done");
        for (int m = 0; m < 8; m++)
        begin
            cout <= rnd();
            coe <= rnd();
            pull <= rnd();
            ext <= rnd();
            repeat (3) @(posedge clk);
            oe0 = coe;
            out0 = cout;
            wreg(`OFS_CTRL, 8'(m % 4 + 4 * (m / 4)));
            @(posedge clk);
            coe <= ~coe;
            cout <= ~cout;
            repeat (3) @(posedge clk);
            #1;
            chk("pad oe", poe, exp_pin(2'(m), m > 3, oe0, coe));
            chk("pad out", pout & poe, exp_pin(2'(m), m > 3, out0 & oe0, cout & coe));
            chk("pull", ppull, pull);
            chk("gate", cin & ~pen, 8'h00);
            chk("blocked", pen & (m % 4 > 1 ? 8'hff : 8'h00), 8'h00);
            chk("standby", stby, m % 4 > 1);
            @(posedge clk);
            wreg(`OFS_CTRL, 8'h00);
        end
        $display("Mode test done");
        coe <= 8'h03;
        wreg(`OFS_OSCSEL, 8'h03);
        wreg(`OFS_TOUCHSEL, 8'hc0);
        for (int k = 0; k < 8; k++)
        begin
            wreg(`OFS_FUNC, 8'(1 << (k % 4)));
            wreg(`OFS_CTRL, 8'(2 + 4 * (k / 4)));
            src <= 4'(rnd());
            repeat (3) @(posedge clk);
            #1;
            e = (k < 4 || k == 7) ? pinm[k % 4] : 8'h00;
            chk("special oe", poe, e);
            chk("special out", pout & poe, e & {8{src[k % 4]}});
            @(posedge clk);
            wreg(`OFS_CTRL, 8'h00);
        end
        $display("Special output test done");
        // Unpulled pads toggle, so external interrupt edges keep coming.
        pull <= 8'h00;
        wreg(`OFS_EXTEN, 8'h30);
        wreg(`OFS_FUNC, 8'h70);
        for (int v = 0; v < 3; v++)
        begin
            wreg(`OFS_MASK, v == 1 ? 8'h04 : 8'h00);
            wreg(`OFS_CTRL, 8'h02);
            ext <= rnd();
            w0 = wakes;
            evs <= 3'(1 << v);
            @(posedge clk);
            evs <= 3'h0;
            #1;
            chk("irq", irq, v == 1);
            chk("ext path", eirq, pad & 8'h30);
            chk("cmp path", cmpen, 8'h20);
            chk("touch path", tin & 8'hc0, pad & 8'hc0);
            chk("i2c path", i2c, pad & 8'h30);
            repeat (2) @(posedge clk);
            #1;
            chk("wake", 8'(wakes - w0), v != 0);
            @(posedge clk);
            rreg(`OFS_STATUS, d);
            chk("status", d, 8'h01 | (8'h02 << v));
        end
        $display("Blocked path test done");
        final_report();
    end
endmodule : standby_pin_state_control_test
`default_nettype wire
